// [design/resolver_port_map.vh]
// Constants for the resolver readout port: pin slots, serial word layout,
// encoder emulation timing and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef RESOLVER_PORT_MAP_VH
`define RESOLVER_PORT_MAP_VH

// Width of angle and velocity words and of the parallel bus
`define DATA_WIDTH 12
// Serial shift register length
`define SERIAL_WIDTH 16

// Slots of the filtered pin vector
`define PIN_COUNT 6
`define PIN_SAMPLE 0
`define PIN_CHIP_SELECT 1
`define PIN_READ 2
`define PIN_VELOCITY_SELECT 3
`define PIN_SERIAL_MODE 4
`define PIN_SERIAL_CLOCK 5
// Idle level of every filtered pin after reset
`define PIN_RESET_LEVEL 6'h3f

// Bus bits reused by the serial interface
`define BUS_SERIAL_OUT 11
`define BUS_SERIAL_CLOCK 10

// Serial word field positions
`define SER_DATA_MSB 15
`define SER_DATA_LSB 4
`define SER_SELECT_BIT 3
`define SER_DEGRADED_BIT 2
`define SER_LOST_BIT 1
`define SER_PARITY_BIT 0

// Encoder update rate: 4.096 MHz from 20 MHz is 512/2500 per cycle
`define QUAD_RATE_STEP 12'h200
`define QUAD_RATE_MODULUS 12'h9c4
`define QUAD_ACC_WIDTH 12

// Quadrature phase encodings of the two low count bits, A leading B upward
`define QUAD_PHASE_0 2'h0
`define QUAD_PHASE_1 2'h1
`define QUAD_PHASE_2 2'h2
`define QUAD_PHASE_3 2'h3

// Count at which the index marker is high: one quarter of an A cycle
`define INDEX_COUNT 12'h000

// Serial frame bit counter: width, cleared value and the count at the sixteenth shift
`define FRAME_COUNT_WIDTH 5
`define FRAME_COUNT_ZERO 5'h00
`define FRAME_LAST_SHIFT 5'h0f

// Reset values and the all-lines drive enable
`define ZERO_WORD 12'h000
`define ZERO_SERIAL 16'h0000
`define ALL_ENABLE 12'hfff

`endif

// [design/pin_filter.v]
// Three-stage input filter for pins from outside the clock domain.
// A new level is accepted once the second and third stages agree.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/10ps
module pin_filter #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b1}}
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out,
    output reg [WIDTH-1:0] level_next_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar i;

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level_out <= RESET_LEVEL;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= level_next_out;
        end
    end

    // Level that will be held after this edge; lets callers act on a change one cycle early
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @* begin
                if (stage2[i] == stage3[i]) begin
                    level_next_out[i] = stage3[i];
                end else begin
                    level_next_out[i] = level_out[i];
                end
            end
        end
    endgenerate
endmodule

// [design/resolver_position_readout_port.v]
// Readout port of a resolver-to-digital converter: holding registers,
// parallel and serial read paths, and 1024-line encoder emulation.
// Assumes angle, velocity and fault flags come from logic on ref_clk_in;
// strobes and the serial clock on bus bit ten arrive asynchronously and are filtered.
//
// Contract
// - Sample strobe falling edge copies angle and velocity into holding registers.
// - Velocity select high picks angle, low picks velocity; host keeps it stable.
// - Selected holding register reaches the output register only with chip select low.
// - Parallel lines float except while chip select and read are both low.
// - Each read falling edge with chip select low freezes the selected value in the output buffer.
// - Read rising releases the parallel lines to high impedance.
// - Serial mode: bit eleven is serial out, bit ten serial clock, rest float.
// - Serial shift register is sixteen bits, sent most significant bit first.
// - Serial bits 15 to 4 hold the value selected at read fall.
// - Angle is unsigned binary, zero meaning zero degrees.
// - Velocity is two's complement, its top bit giving direction.
// - Bit 3 echoes select, bit 2 degradation flag, bit 1 tracking loss.
// - Bit 0 is odd parity over the whole sixteen-bit word.
// - MSB present before first serial falling edge; later bits shift on rising edges.
// - Clocks beyond sixteen shift out zeros while read stays low.
// - Encoder outputs emulate 1024 lines, 1024 pulses per turn per channel.
// - Channel A leads B for rising angle; direction high for rising angle.
// - Index marker high for a quarter A cycle as angle passes zero.
// - At most one quadrature step per 4.096 MHz tick, four steps a pulse.
`timescale 1ns/10ps
`include "resolver_port_map.vh"
module resolver_position_readout_port #(
    parameter DATA_WIDTH = `DATA_WIDTH,
    parameter SERIAL_WIDTH = `SERIAL_WIDTH,
    parameter [`QUAD_ACC_WIDTH-1:0] QUAD_RATE_STEP = `QUAD_RATE_STEP,
    parameter [`QUAD_ACC_WIDTH-1:0] QUAD_RATE_MODULUS = `QUAD_RATE_MODULUS
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [DATA_WIDTH-1:0] position_in,
    input wire [DATA_WIDTH-1:0] velocity_in,
    input wire signal_degraded_flag_in,
    input wire tracking_lost_flag_in,
    input wire sample_n_in,
    input wire chip_select_n_in,
    input wire read_n_in,
    input wire velocity_select_n_in,
    input wire serial_mode_select_n_in,
    input wire [DATA_WIDTH-1:0] bus_data_in,
    output reg [DATA_WIDTH-1:0] bus_data_out,
    output reg [DATA_WIDTH-1:0] bus_data_oe_out,
    output reg quad_a_out,
    output reg quad_b_out,
    output reg index_marker_out,
    output reg direction_out
);
    // Filtered pin levels, current and about to be taken
    wire [`PIN_COUNT-1:0] pin_raw;
    wire [`PIN_COUNT-1:0] pin_level;
    wire [`PIN_COUNT-1:0] pin_next;

    wire sample_fall;
    wire read_fall;
    wire read_low_next;
    wire chip_selected_next;
    wire serial_clock_rise;
    wire serial_mode_next;
    wire select_angle;

    // Holding and output registers
    reg [DATA_WIDTH-1:0] position_hold;
    reg [DATA_WIDTH-1:0] velocity_hold;
    reg [DATA_WIDTH-1:0] parallel_word;
    reg [SERIAL_WIDTH-1:0] shift_word;

    reg [DATA_WIDTH-1:0] selected_value;
    reg [SERIAL_WIDTH-1:0] load_word;
    reg [DATA_WIDTH-1:0] next_parallel_word;
    reg [SERIAL_WIDTH-1:0] next_shift_word;
    reg [DATA_WIDTH-1:0] next_bus_data;
    reg [DATA_WIDTH-1:0] next_bus_oe;

    // Encoder emulation state
    reg [`QUAD_ACC_WIDTH-1:0] rate_acc;
    reg quad_tick;
    reg [DATA_WIDTH-1:0] quad_count;
    reg [DATA_WIDTH-1:0] next_quad_count;
    reg next_direction;
    reg next_quad_a;
    reg next_quad_b;
    wire [DATA_WIDTH-1:0] quad_gap;

    // Serial frame state, one-hot
    localparam [2:0] FRAME_IDLE = 3'h1;
    localparam [2:0] FRAME_SHIFT = 3'h2;
    localparam [2:0] FRAME_DRAIN = 3'h4;
    reg [2:0] frame_state;
    reg [2:0] next_frame_state;
    reg [`FRAME_COUNT_WIDTH-1:0] bits_sent;
    reg [`FRAME_COUNT_WIDTH-1:0] next_bits_sent;
    wire frame_open;
    wire frame_shift;

    assign pin_raw[`PIN_SAMPLE] = sample_n_in;
    assign pin_raw[`PIN_CHIP_SELECT] = chip_select_n_in;
    assign pin_raw[`PIN_READ] = read_n_in;
    assign pin_raw[`PIN_VELOCITY_SELECT] = velocity_select_n_in;
    assign pin_raw[`PIN_SERIAL_MODE] = serial_mode_select_n_in;
    assign pin_raw[`PIN_SERIAL_CLOCK] = bus_data_in[`BUS_SERIAL_CLOCK];

    pin_filter #(
        .WIDTH(`PIN_COUNT),
        .RESET_LEVEL(`PIN_RESET_LEVEL)
    ) u_pin_filter (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .pin_in(pin_raw),
        .level_out(pin_level),
        .level_next_out(pin_next)
    );

    assign sample_fall = pin_level[`PIN_SAMPLE] & ~pin_next[`PIN_SAMPLE];
    assign read_fall = pin_level[`PIN_READ] & ~pin_next[`PIN_READ];
    assign read_low_next = ~pin_next[`PIN_READ];
    assign chip_selected_next = ~pin_next[`PIN_CHIP_SELECT];
    assign serial_clock_rise = ~pin_level[`PIN_SERIAL_CLOCK] & pin_next[`PIN_SERIAL_CLOCK];
    assign serial_mode_next = ~pin_next[`PIN_SERIAL_MODE];
    // Shifts count only inside an open serial frame and in serial mode
    assign frame_open = (frame_state != FRAME_IDLE);
    assign frame_shift = serial_clock_rise & read_low_next & chip_selected_next & serial_mode_next & frame_open;
    // Select is sampled at the read fall; the host keeps it settled before then
    assign select_angle = pin_next[`PIN_VELOCITY_SELECT];

    // Integrator values copied on the sample fall; tracking keeps running
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            position_hold <= `ZERO_WORD;
            velocity_hold <= `ZERO_WORD;
        end else if (sample_fall) begin
            position_hold <= position_in;
            velocity_hold <= velocity_in;
        end
    end

    // Word assembled at the read fall, from the register that select names
    always @* begin
        if (select_angle) begin
            selected_value = position_hold;
        end else begin
            selected_value = velocity_hold;
        end
        load_word = `ZERO_SERIAL;
        load_word[`SER_DATA_MSB:`SER_DATA_LSB] = selected_value;
        load_word[`SER_SELECT_BIT] = select_angle;
        load_word[`SER_DEGRADED_BIT] = signal_degraded_flag_in;
        load_word[`SER_LOST_BIT] = tracking_lost_flag_in;
        // Odd parity: the parity bit completes an odd count of ones
        load_word[`SER_PARITY_BIT] = ~(^load_word[`SER_DATA_MSB:`SER_LOST_BIT]);
    end

    // Output buffer frozen per read; loaded only with chip select low
    always @* begin
        next_parallel_word = parallel_word;
        if (read_fall && chip_selected_next) begin
            next_parallel_word = selected_value;
        end
    end

    // Serial shifter: loads whole word on read fall, shifts on each serial rising edge
    always @* begin
        next_shift_word = shift_word;
        if (read_fall && chip_selected_next) begin
            next_shift_word = load_word;
        end else if (frame_shift) begin
            if (frame_state == FRAME_DRAIN) begin
                // Frame already delivered sixteen bits: only zeros follow
                next_shift_word = `ZERO_SERIAL;
            end else begin
                // Zero fill means the sixteenth shift already leaves zeros behind
                next_shift_word = {shift_word[SERIAL_WIDTH-2:0], 1'b0};
            end
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            parallel_word <= `ZERO_WORD;
            shift_word <= `ZERO_SERIAL;
        end else begin
            parallel_word <= next_parallel_word;
            shift_word <= next_shift_word;
        end
    end

    // Frame opens at a selected read fall, drains after sixteen shifts, closes on read rise
    always @* begin
        next_frame_state = frame_state;
        next_bits_sent = bits_sent;
        if (read_fall && chip_selected_next) begin
            next_frame_state = FRAME_SHIFT;
            next_bits_sent = `FRAME_COUNT_ZERO;
        end else begin
            case (frame_state)
                FRAME_IDLE: begin
                    next_frame_state = FRAME_IDLE;
                end
                FRAME_SHIFT: begin
                    if (!read_low_next) begin
                        next_frame_state = FRAME_IDLE;
                    end else if (frame_shift) begin
                        next_bits_sent = bits_sent + 1'b1;
                        if (bits_sent == `FRAME_LAST_SHIFT) begin
                            next_frame_state = FRAME_DRAIN;
                        end
                    end
                end
                FRAME_DRAIN: begin
                    if (!read_low_next) begin
                        next_frame_state = FRAME_IDLE;
                    end
                end
                default: begin
                    next_frame_state = FRAME_IDLE;
                end
            endcase
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            frame_state <= FRAME_IDLE;
            bits_sent <= `FRAME_COUNT_ZERO;
        end else begin
            frame_state <= next_frame_state;
            bits_sent <= next_bits_sent;
        end
    end

    // Pin drive, computed from next values so the data and enable rise together
    always @* begin
        next_bus_data = `ZERO_WORD;
        next_bus_oe = `ZERO_WORD;
        if (serial_mode_next) begin
            next_bus_data[`BUS_SERIAL_OUT] = next_shift_word[SERIAL_WIDTH-1];
            if (chip_selected_next && read_low_next) begin
                // Only serial out drives; serial clock and the low ten bits stay released
                next_bus_oe[`BUS_SERIAL_OUT] = 1'b1;
            end
        end else begin
            next_bus_data = next_parallel_word;
            if (chip_selected_next && read_low_next) begin
                next_bus_oe = `ALL_ENABLE;
            end
        end
        // Released as soon as read goes back high
        if (!read_low_next) begin
            next_bus_oe = `ZERO_WORD;
        end
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            bus_data_out <= `ZERO_WORD;
            bus_data_oe_out <= `ZERO_WORD;
        end else begin
            bus_data_out <= next_bus_data;
            bus_data_oe_out <= next_bus_oe;
        end
    end

    // Fractional divider: one tick per 4.096 MHz period on average
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            rate_acc <= {`QUAD_ACC_WIDTH{1'b0}};
            quad_tick <= 1'b0;
        end else if (rate_acc >= QUAD_RATE_MODULUS - QUAD_RATE_STEP) begin
            rate_acc <= rate_acc + QUAD_RATE_STEP - QUAD_RATE_MODULUS;
            quad_tick <= 1'b1;
        end else begin
            rate_acc <= rate_acc + QUAD_RATE_STEP;
            quad_tick <= 1'b0;
        end
    end

    // Encoder count chases the live angle by one step per tick, shortest way round
    assign quad_gap = position_in - quad_count;

    always @* begin
        next_quad_count = quad_count;
        next_direction = direction_out;
        if (quad_tick && quad_gap != `ZERO_WORD) begin
            if (!quad_gap[DATA_WIDTH-1]) begin
                next_quad_count = quad_count + 1'b1;
                next_direction = 1'b1;
            end else begin
                next_quad_count = quad_count - 1'b1;
                next_direction = 1'b0;
            end
        end
    end

    // Four count steps per A cycle give 1024 pulses over 4096 counts
    always @* begin
        case (next_quad_count[1:0])
            `QUAD_PHASE_0: begin
                next_quad_a = 1'b0;
                next_quad_b = 1'b0;
            end
            `QUAD_PHASE_1: begin
                next_quad_a = 1'b1;
                next_quad_b = 1'b0;
            end
            `QUAD_PHASE_2: begin
                next_quad_a = 1'b1;
                next_quad_b = 1'b1;
            end
            `QUAD_PHASE_3: begin
                next_quad_a = 1'b0;
                next_quad_b = 1'b1;
            end
            default: begin
                next_quad_a = 1'b0;
                next_quad_b = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            quad_count <= `ZERO_WORD;
            quad_a_out <= 1'b0;
            quad_b_out <= 1'b0;
            index_marker_out <= 1'b0;
            direction_out <= 1'b0;
        end else begin
            quad_count <= next_quad_count;
            quad_a_out <= next_quad_a;
            quad_b_out <= next_quad_b;
            index_marker_out <= (next_quad_count == `INDEX_COUNT);
            direction_out <= next_direction;
        end
    end
endmodule

// [bench/resolver_position_readout_port_asserts.sv]
// Pin-level checker for the resolver readout port.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/10ps
module readout_port_checker #(
    parameter DATA_WIDTH = 12
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire chip_select_n_in,
    input wire read_n_in,
    input wire serial_mode_select_n_in,
    input wire [DATA_WIDTH-1:0] bus_data_out,
    input wire [DATA_WIDTH-1:0] bus_data_oe_out,
    input wire quad_a_out,
    input wire quad_b_out,
    input wire index_marker_out,
    input wire direction_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    release_float_a: assert property (read_n_in [*5] |-> bus_data_oe_out == '0)
        else $error("bus driven after read release");
    parallel_drive_a: assert property ((!chip_select_n_in && !read_n_in && serial_mode_select_n_in) [*5]
        |-> bus_data_oe_out == '1) else $error("bus not driven during read");
    serial_pins_a: assert property (!serial_mode_select_n_in [*5] |-> bus_data_oe_out[10:0] == '0)
        else $error("low bus lines driven in serial mode");
    read_frozen_a: assert property ((!chip_select_n_in && !read_n_in && serial_mode_select_n_in) [*6]
        |-> $stable(bus_data_out)) else $error("read data moved during read");
    step_spacing_a: assert property ($changed({quad_a_out, quad_b_out}) |=> $stable({quad_a_out, quad_b_out}) [*3])
        else $error("encoder steps too close");
    quad_up_a: assert property ($changed({quad_a_out, quad_b_out}) && direction_out
        |-> {quad_a_out, quad_b_out} == {!$past(quad_b_out), $past(quad_a_out)}) else $error("bad upward step");
    quad_down_a: assert property ($changed({quad_a_out, quad_b_out}) && !direction_out
        |-> {quad_a_out, quad_b_out} == {$past(quad_b_out), !$past(quad_a_out)}) else $error("bad downward step");
    index_phase_a: assert property (index_marker_out |-> !quad_a_out && !quad_b_out)
        else $error("index outside its quarter");
endmodule

bind resolver_position_readout_port readout_port_checker #(.DATA_WIDTH(DATA_WIDTH)) i_checker (
    .ref_clk_in, .reset_in, .chip_select_n_in, .read_n_in, .serial_mode_select_n_in,
    .bus_data_out, .bus_data_oe_out, .quad_a_out, .quad_b_out, .index_marker_out, .direction_out);

// [bench/readout_host_model.sv]
// Host controller model: latch strobe, reads and the serial clock.
// Assumes the bench resolves the bus wire and returns bit eleven.
`timescale 1ns/10ps
module readout_host_model (
    input wire ref_clk_in,
    input wire serial_data_in,
    output reg sample_n_out,
    output reg chip_select_n_out,
    output reg read_n_out,
    output reg velocity_select_n_out,
    output reg serial_mode_select_n_out,
    output reg serial_clock_out
);
    initial begin
        {sample_n_out, chip_select_n_out, read_n_out} = 3'h7;
        {velocity_select_n_out, serial_mode_select_n_out, serial_clock_out} = 3'h7;
    end
    task latch_values;
        @(posedge ref_clk_in) sample_n_out <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        sample_n_out <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
    endtask
    task set_mode(input logic m);
        @(posedge ref_clk_in) serial_mode_select_n_out <= m;
        repeat (6) @(posedge ref_clk_in);
    endtask
    task read_begin(input logic sel, input logic cs_low);
        @(posedge ref_clk_in) velocity_select_n_out <= sel;
        chip_select_n_out <= !cs_low;
        repeat (2) @(posedge ref_clk_in);
        read_n_out <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        #10;
    endtask
    task read_end;
        @(posedge ref_clk_in) read_n_out <= 1'b1;
        chip_select_n_out <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
    endtask
    // Clock idles high; falls on a ref edge, host samples late in the low phase, then rises
    task ser_read(input logic sel, input int n, output logic [17:0] w);
        w = 18'h0;
        read_begin(sel, 1'b1);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_in) serial_clock_out <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            @(negedge ref_clk_in) w = {w[16:0], serial_data_in};
            @(posedge ref_clk_in) serial_clock_out <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
        end
        read_end;
    endtask
endmodule

// [bench/resolver_position_readout_port_bench.sv]
// Self-checking bench: encoder moves, parallel and serial reads.
// Assumes the host model drives all strobes; bench drives the live values.
`timescale 1ns/10ps
module resolver_position_readout_port_bench;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] position_in = 12'h000;
    logic [11:0] velocity_in = 12'h000;
    logic signal_degraded_flag = 1'b0;
    logic tracking_lost_flag = 1'b0;
    wire sample_n, cs_n, rd_n, vsel_n, mode_n, sclk, qa, qb, idx, dir;
    wire [11:0] bus_out, bus_oe, bus_in;
    int error_cnt = 0;
    int total_checks = 0;
    int a_rises = 0;
    logic [15:0] seed = 16'h0042;
    logic [11:0] pos, vel;
    logic [15:0] word;
    logic [17:0] w;
    logic [11:0] enc_pos [3] = '{12'h005, 12'h002, 12'h000};
    logic [3:0] enc_exp [3] = '{4'ha, 4'hc, 4'h1};

    always #25 ref_clk_in = ~ref_clk_in;
    always @(posedge qa) a_rises++;
    // Driven lines show the DUT data output, released lines its inverse, except bit ten, which when released carries the serial clock
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & {~bus_out[11], sclk, ~bus_out[9:0]});

    resolver_position_readout_port i_dut (.ref_clk_in, .reset_in, .position_in, .velocity_in,
        .signal_degraded_flag_in(signal_degraded_flag), .tracking_lost_flag_in(tracking_lost_flag),
        .sample_n_in(sample_n), .chip_select_n_in(cs_n), .read_n_in(rd_n), .velocity_select_n_in(vsel_n),
        .serial_mode_select_n_in(mode_n), .bus_data_in(bus_in), .bus_data_out(bus_out),
        .bus_data_oe_out(bus_oe), .quad_a_out(qa), .quad_b_out(qb), .index_marker_out(idx),
        .direction_out(dir));
    readout_host_model i_host (.ref_clk_in, .serial_data_in(bus_in[11]), .sample_n_out(sample_n),
        .chip_select_n_out(cs_n), .read_n_out(rd_n), .velocity_select_n_out(vsel_n),
        .serial_mode_select_n_out(mode_n), .serial_clock_out(sclk));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] ser_word(input logic [11:0] v, input logic s);
        return {v, s, signal_degraded_flag, tracking_lost_flag,
            ~^{v, s, signal_degraded_flag, tracking_lost_flag}};
    endfunction
    task check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        error_cnt++;
        final_report;
    end

    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        #10;
        check(18'(bus_oe), 18'h0);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_in) position_in <= enc_pos[k];
            repeat (60) @(posedge ref_clk_in);
            #10;
            check(18'({qa, qb, dir, idx}), 18'(enc_exp[k]));
        end
        a_rises = 0;
        @(posedge ref_clk_in) position_in <= 12'h7ff;
        repeat (10600) @(posedge ref_clk_in);
        check(18'(a_rises), 18'h200);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr_next(seed);
            pos = seed[11:0];
            seed = lfsr_next(seed);
            vel = seed[11:0];
            @(posedge ref_clk_in) position_in <= pos;
            velocity_in <= vel;
            signal_degraded_flag <= seed[12];
            tracking_lost_flag <= seed[13];
            i_host.latch_values;
            @(posedge ref_clk_in) position_in <= ~pos;
            velocity_in <= ~vel;
            i_host.read_begin(1'b1, 1'b1);
            check(18'(bus_out), 18'(pos));
            i_host.read_end;
            check(18'(bus_oe), 18'h0);
            i_host.read_begin(1'b0, 1'b1);
            check(18'(bus_out), 18'(vel));
            i_host.read_end;
            i_host.read_begin(1'b1, 1'b0);
            check(18'(bus_oe), 18'h0);
            check(18'(bus_out), 18'(vel));
            i_host.read_end;
            i_host.set_mode(1'b0);
            word = ser_word(pos, 1'b1);
            i_host.ser_read(1'b1, 5, w);
            check(18'(w[4:0]), 18'(word[15:11]));
            i_host.ser_read(1'b1, 18, w);
            check(w, {word, 2'h0});
            i_host.ser_read(1'b0, 18, w);
            check(w, {ser_word(vel, 1'b0), 2'h0});
            i_host.set_mode(1'b1);
        end
        final_report;
    end
endmodule
